/* File: rtl/eepw_top.sv */
// Purpose: two-wire eeprom slave, addressing and write path
// Assumes: bus pins sampled by the 10 MHz reference clock
// Notes: read transfers are acked at select and then ignored
`timescale 1ns/100ps

module eepw_fifo #(
  parameter int W = 13,
  parameter int D = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [0:D-1];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire full = (wp_q[AW] != rp_q[AW]) & (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready_o = ~full;
  assign out_valid_o = wp_q != rp_q;
  assign out_data_o = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (push) mem_q[wp_q[AW-1:0]] <= in_data_i;
  end
endmodule

module eepw_top import eepw_pkg::*; #(
  parameter int WRITE_CYCLES = EEPW_WRITE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic chip_select_bit0_i,
  input wire logic chip_select_bit1_i,
  input wire logic chip_select_bit2_i,
  input wire logic write_protect_input_i,
  output logic busy_o,
  output logic id_locked_o
);
  eepw_state_t state_q;
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p, wp_m, wp_s;
  logic [2:0] cs_m, cs_s;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic oe_q, lo_q, slot10_q, id_q, lock_pend_q, locked_q, busy_q;
  logic [15:0] addr_q;
  logic [4:0] off_q, last_q;
  logic [7:0] pg_q [0:31];
  logic [31:0] msk_q;
  logic [3:0] wi_q;
  logic [16:0] wt_q;
  logic [37:0] mem_q [0:EEPW_MEM_WORDS-1];

  wire start = scl_s & scl_p & sda_p & ~sda_s;
  wire stop = scl_s & scl_p & ~sda_p & sda_s;
  wire rise = scl_s & ~scl_p;
  wire fall = ~scl_s & scl_p;
  wire busy = state_q == EEPW_BUSY;
  wire at_ack = fall & (cnt_q == EEPW_ACK_CNT) & ~busy;
  wire at_rel = fall & (cnt_q == EEPW_REL_CNT);
  wire type_ok = (sh_q[7:4] == EEPW_TYPE_MAIN) | (sh_q[7:4] == EEPW_TYPE_ID);
  wire sel_ok = type_ok & (sh_q[3:1] == cs_s);
  wire lock_cmd = id_q & addr_q[EEPW_LOCK_ADDR_BIT];
  wire in_ready;
  wire data_ok = ~wp_s & in_ready & ~(id_q & locked_q);
  wire push = at_ack & (state_q == EEPW_DATA) & data_ok & ~lock_cmd;
  wire stop_go = stop & slot10_q & ~busy & ((|msk_q) | lock_pend_q);
  logic ack_d;
  always_comb begin
    case (state_q)
      EEPW_DEVSEL: ack_d = sel_ok;
      EEPW_ADDR_HI: ack_d = 1'b1;
      EEPW_ADDR_LO: ack_d = 1'b1;
      EEPW_DATA: ack_d = data_ok;
      default: ack_d = 1'b0;
    endcase
  end

  eepw_byte_t in_b, out_b;
  logic out_valid;
  wire pop = out_valid & ~busy;
  assign in_b = '{off: off_q, data: sh_q};
  eepw_fifo #(.W($bits(eepw_byte_t)), .D(EEPW_FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(in_ready),
    .in_data_i(in_b),
    .out_valid_o(out_valid),
    .out_ready_i(~busy),
    .out_data_o(out_b)
  );

  // commit path: one word per cycle, then the write timer
  // row select: main array row from addr_q, or row 0 of the id page
  wire [11:0] idx = {id_q, id_q ? 8'h00 : addr_q[12:5], wi_q[2:0]};
  wire [37:0] rd_w = mem_q[idx];
  wire [31:0] fixed = eepw_ecc_fix(rd_w[31:0], rd_w[37:32]);
  wire [3:0] wmsk = msk_q[{wi_q[2:0], 2'b00} +: 4];
  logic [31:0] merged;
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign merged[8*g +: 8] = wmsk[g] ? pg_q[{wi_q[2:0], 2'(g)}]
                                      : fixed[8*g +: 8];
  end
  wire in_commit = busy & ~wi_q[3];
  wire wt_done = wi_q[3] & (wt_q == 17'(WRITE_CYCLES - 1));

  // whole word and check bits rewritten
  always_ff @(posedge ref_clk_i) begin
    if (in_commit & (|wmsk))
      mem_q[idx] <= {eepw_ecc_syn(merged, 6'h00), merged};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_m, scl_s, scl_p, sda_m, sda_s, sda_p} <= 6'h3F;
      {wp_m, wp_s} <= 2'h0;
      cs_m <= 3'h0;
      cs_s <= 3'h0;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      {wp_m, wp_s} <= {write_protect_input_i, wp_m};
      cs_m <= {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};
      cs_s <= cs_m;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
    end else if (start & ~busy) begin
      cnt_q <= 4'h0;
    end else if (rise & (cnt_q < EEPW_REL_CNT)) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q < EEPW_ACK_CNT) sh_q <= {sh_q[6:0], sda_s};
    end else if (at_rel) begin
      cnt_q <= 4'h0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_q <= 1'b0;
      lo_q <= 1'b0;
      slot10_q <= 1'b0;
    end else begin
      lo_q <= 1'b0;
      if (busy | start | stop) oe_q <= 1'b0;
      else if (at_ack) oe_q <= ack_d;
      else if (at_rel) oe_q <= 1'b0;
      // mark slot after a data ack
      if (at_rel) slot10_q <= (state_q == EEPW_DATA) & oe_q;
      else if (fall | start) slot10_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= EEPW_IDLE;
      id_q <= 1'b0;
      addr_q <= EEPW_ADDR_RST;
      off_q <= EEPW_OFF_RST;
      lock_pend_q <= 1'b0;
      locked_q <= 1'b0;
      wi_q <= EEPW_WI_RST;
      wt_q <= EEPW_WT_RST;
      busy_q <= 1'b0;
    end else if (busy) begin
      if (~wi_q[3]) wi_q <= wi_q + 4'h1;
      else wt_q <= wt_q + 17'h1;
      if (wt_done) begin
        state_q <= EEPW_IDLE;
        if (~lock_pend_q) addr_q <= {addr_q[15:5], last_q} + 16'h1;
        if (lock_pend_q) locked_q <= 1'b1;
        lock_pend_q <= 1'b0;
        busy_q <= 1'b0;
      end
    end else if (start) begin
      state_q <= EEPW_DEVSEL;
      lock_pend_q <= 1'b0;
    end else if (stop) begin
      // only the slot-ten stop starts a write
      state_q <= stop_go ? EEPW_BUSY : EEPW_IDLE;
      wi_q <= EEPW_WI_RST;
      wt_q <= EEPW_WT_RST;
      if (~stop_go) lock_pend_q <= 1'b0;
      busy_q <= stop_go;
    end else if (at_ack) begin
      case (state_q)
        EEPW_DEVSEL: begin
          id_q <= sh_q[7:4] == EEPW_TYPE_ID;
          state_q <= (sel_ok & ~sh_q[0]) ? EEPW_ADDR_HI : EEPW_IGNORE;
        end
        EEPW_ADDR_HI: begin
          addr_q[15:8] <= sh_q;
          state_q <= EEPW_ADDR_LO;
        end
        EEPW_ADDR_LO: begin
          addr_q[7:0] <= sh_q;
          off_q <= sh_q[4:0];
          state_q <= EEPW_DATA;
        end
        EEPW_DATA: begin
          if (~data_ok) state_q <= EEPW_IGNORE;
          else if (lock_cmd) lock_pend_q <= sh_q[EEPW_LOCK_DATA_BIT];
          else off_q <= off_q + 5'h1;
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // page latch and byte mask; mask cleared by start and at write end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      msk_q <= 32'h0000_0000;
      last_q <= EEPW_OFF_RST;
    end else if (wt_done | (start & ~busy)) begin
      msk_q <= 32'h0000_0000;
    end else if (pop) begin
      msk_q[out_b.off] <= 1'b1;
      last_q <= out_b.off;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (pop) pg_q[out_b.off] <= out_b.data;
  end

  assign sda_o = lo_q;
  assign sda_oe_o = oe_q;
  assign busy_o = busy_q;
  assign id_locked_o = locked_q;

  chk_ack_select: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    at_ack & (state_q == EEPW_DEVSEL) & sel_ok & ~start & ~stop
    |=> sda_oe_o) else $error("select not acked");
  chk_mismatch_standby: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    at_ack & (state_q == EEPW_DEVSEL) & ~sel_ok & ~start & ~stop
    |=> !sda_oe_o && state_q == EEPW_IGNORE)
    else $error("mismatch not ignored");
  chk_ack_release: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    at_rel |=> !sda_oe_o) else $error("ack held too long");
  chk_busy_quiet: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    busy ##1 busy |-> !sda_oe_o) else $error("line driven busy");
  chk_wp_nack: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    at_ack & (state_q == EEPW_DATA) & wp_s |=> !sda_oe_o && !busy)
    else $error("protected byte acked");
  chk_addr_ack: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    at_ack & ((state_q == EEPW_ADDR_HI) | (state_q == EEPW_ADDR_LO))
    & ~start & ~stop |=> sda_oe_o) else $error("address not acked");
  chk_stop_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    stop_go |=> busy_o) else $error("write not started");
  chk_stray_stop: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    stop & ~busy & ~slot10_q |=> !busy_o)
    else $error("stray stop wrote");
  chk_locked_nack: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    at_ack & (state_q == EEPW_DATA) & id_q & locked_q |=> !sda_oe_o)
    else $error("locked page acked");
  chk_offset_wrap: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    push |=> off_q == $past(off_q) + 5'h1)
    else $error("offset not advanced");
  chk_bit_sample: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rise & (cnt_q < EEPW_ACK_CNT) & ~start & ~busy
    |=> sh_q[0] == $past(sda_s)) else $error("bit not sampled");
  chk_addr_advance: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wt_done & ~lock_pend_q |=> addr_q[4:0] == $past(last_q) + 5'h1)
    else $error("address not advanced");
  chk_lock_set: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    wt_done & lock_pend_q |=> id_locked_o) else $error("lock not set");
  cov_write: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    stop_go & ~id_q);
  cov_id_write: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    stop_go & id_q & ~lock_pend_q);
  cov_lock: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    wt_done & lock_pend_q);
  cov_wp: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    at_ack & (state_q == EEPW_DATA) & wp_s);
endmodule

/* File: rtl/eepw_pkg.sv */
// Purpose: shared constants, types and ecc functions for the eeprom slave
// Assumes: 10 MHz reference clock
// Notes: ecc is a 38-bit hamming code over 32-bit words
package eepw_pkg;
  localparam logic [3:0] EEPW_TYPE_MAIN = 4'hA;
  localparam logic [3:0] EEPW_TYPE_ID = 4'hB;
  localparam logic [3:0] EEPW_ACK_CNT = 4'h8;
  localparam logic [3:0] EEPW_REL_CNT = 4'h9;
  localparam int EEPW_LOCK_ADDR_BIT = 10;
  localparam int EEPW_LOCK_DATA_BIT = 1;
  localparam int EEPW_ROW_WORDS = 8;
  localparam int EEPW_MEM_WORDS = 2056;
  localparam int EEPW_FIFO_DEPTH = 8;
  localparam int EEPW_CLK_MHZ = 10;
  localparam int EEPW_WRITE_TIME_US = 5000;
  localparam int EEPW_WRITE_CYC = EEPW_WRITE_TIME_US * EEPW_CLK_MHZ;
  localparam logic [15:0] EEPW_ADDR_RST = 16'h0000;
  localparam logic [4:0] EEPW_OFF_RST = 5'h00;
  localparam logic [16:0] EEPW_WT_RST = 17'h00000;
  localparam logic [3:0] EEPW_WI_RST = 4'h0;

  typedef enum {
    EEPW_IDLE, EEPW_DEVSEL, EEPW_ADDR_HI, EEPW_ADDR_LO, EEPW_DATA,
    EEPW_IGNORE, EEPW_BUSY
  } eepw_state_t;

  typedef struct packed {
    logic [4:0] off;
    logic [7:0] data;
  } eepw_byte_t;

  // syndrome over positions 1..38, check bits at powers of two
  function automatic logic [5:0] eepw_ecc_syn(input logic [31:0] d,
                                              input logic [5:0] c);
    logic [5:0] s;
    int k;
    s = c;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) s = s ^ p[5:0];
        k++;
      end
    end
    return s;
  endfunction

  function automatic logic [31:0] eepw_ecc_fix(input logic [31:0] d,
                                               input logic [5:0] c);
    logic [5:0] s;
    logic [31:0] r;
    int k;
    s = eepw_ecc_syn(d, c);
    r = d;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (s == p[5:0]) r[k] = ~r[k];
        k++;
      end
    end
    return r;
  endfunction
endpackage

/* File: dv/eepw_master.sv */
// Purpose: two-wire bus master model for the eeprom write slave
// Assumes: data line pulled up, device acks by pulling low
// Notes: clock stands high between frames; slow stretches clock low
`timescale 1ns/100ps
module eepw_master (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  int slow = 0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold(input int n);
    #(n * 100);
  endtask
  task automatic start();
    sda_o = 1'b1;
    hold(2);
    sda_o = 1'b0;
    hold(2);
    scl_o = 1'b0;
    hold(1);
  endtask
  // data changes only while clock low
  task automatic bit_out(input logic b);
    sda_o = b;
    hold(3 + slow);
    scl_o = 1'b1;
    hold(4);
    scl_o = 1'b0;
    hold(1);
  endtask
  // msb first; release data on ninth clock
  task automatic byte_out(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    sda_o = 1'b1;
    hold(3 + slow);
    scl_o = 1'b1;
    hold(2);
    ack = ~sda_i;
    hold(2);
    scl_o = 1'b0;
    hold(1);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    hold(2);
    scl_o = 1'b1;
    hold(2);
    sda_o = 1'b1;
    hold(4);
  endtask
endmodule

/* File: dv/test_eepw_top.sv */
// Purpose: self-checking bench for the eeprom write slave
// Assumes: master model drives the bus, open-drain data line
// Notes: write cycle shortened through WRITE_CYCLES
`timescale 1ns/100ps
module test_eepw_top;
  import eepw_pkg::*;
  localparam int WCYC = 200;
  logic ref_clk_i, rst_i, wp, locked_exp, poll;
  logic [2:0] pins;
  logic scl, m_sda, sda_o, sda_oe_o, busy_o, id_locked_o;
  wire sda_line = m_sda & ~(sda_oe_o & ~sda_o);
  int fails = 0;
  int num_checks = 0;
  int seed = 22088;
  time busy_t = 0;
  always @(posedge busy_o) busy_t = $time;
  eepw_top #(.WRITE_CYCLES(WCYC)) uut (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .chip_select_bit0_i(pins[0]),
    .chip_select_bit1_i(pins[1]), .chip_select_bit2_i(pins[2]),
    .write_protect_input_i(wp), .busy_o(busy_o),
    .id_locked_o(id_locked_o));
  eepw_master m (.sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d, errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic got, input logic exp, input string s);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %b exp %b", $time, s, got, exp);
    end
  endtask
  task automatic check_n(input int got, input int exp, input string s);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("Error at %0t: %s got %0d exp %0d", $time, s, got, exp);
    end
  endtask
  function automatic logic sel_ok(input logic [3:0] ty,
                                  input logic [2:0] ce);
    return (ty == EEPW_TYPE_MAIN || ty == EEPW_TYPE_ID) && ce == pins;
  endfunction
  function automatic logic dat_ok(input logic [3:0] ty);
    return !wp && !(ty == EEPW_TYPE_ID && locked_exp);
  endfunction
  task automatic wait_busy(input logic e);
    int k;
    k = 0;
    if (e) begin
      while (busy_o !== 1'b1 && k < 20) begin
        @(negedge ref_clk_i);
        k++;
      end
      check(busy_o, 1'b1, "write start");
      if (poll) return;
      k = 0;
      while (busy_o === 1'b1 && k < 400) begin
        @(negedge ref_clk_i);
        k++;
      end
      check_n(int'(($time - busy_t) / 100), 8 + WCYC, "busy length");
    end else begin
      while (busy_o === 1'b1 && k < 400) begin
        @(negedge ref_clk_i);
        k++;
      end
      repeat (10) begin
        @(negedge ref_clk_i);
        if (busy_o !== 1'b0) e = 1'b1;
      end
      check(e, 1'b0, "no write");
    end
  endtask
  task automatic wr(input logic [3:0] ty, input logic [2:0] ce,
                    input logic rw, input logic [15:0] a, input int n,
                    input int na, input logic [7:0] d);
    logic ack, s, dk, eb;
    s = sel_ok(ty, ce) && busy_o !== 1'b1;
    dk = dat_ok(ty);
    m.start();
    m.byte_out({ty, ce, rw}, ack);
    check(ack, s, "select ack");
    for (int i = 0; i < na && s && !rw; i++) begin
      m.byte_out(i == 0 ? a[15:8] : a[7:0], ack);
      check(ack, 1'b1, "address ack");
    end
    for (int i = 0; i < n && s && !rw && na == 2; i++) begin
      m.byte_out(d + 8'(i), ack);
      check(ack, dk, "data ack");
    end
    m.stop();
    eb = s && !rw && na == 2 && n > 0 && dk;
    eb = eb && !(ty == EEPW_TYPE_ID && a[10] && !d[1]);
    wait_busy(eb);
    if (eb && ty == EEPW_TYPE_ID && a[10]) locked_exp = 1'b1;
    check(id_locked_o, locked_exp, "lock flag");
  endtask
  always @(negedge ref_clk_i) begin
    if (busy_o === 1'b1) check(sda_oe_o, 1'b0, "drive while busy");
  end
  initial begin
    #(8_000_000);
    fails++;
    $display("Error at %0t: run timed out", $time);
    print_verdict();
  end
  initial begin
    logic [31:0] r;
    rst_i = 1'b1;
    wp = 1'b0;
    pins = 3'h5;
    locked_exp = 1'b0;
    poll = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check(id_locked_o, 1'b0, "reset lock");
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h1234, 1, 2, 8'h5A);
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h03E1, 32, 2, 8'h00);
    wr(EEPW_TYPE_MAIN, 3'h2, 1'b0, 16'h0010, 1, 2, 8'h11);
    wr(4'h9, 3'h5, 1'b0, 16'h0010, 1, 2, 8'h11);
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b1, 16'h0000, 0, 0, 8'h00);
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h0020, 0, 1, 8'h00);
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h0020, 0, 2, 8'h00);
    @(negedge ref_clk_i);
    wp = 1'b1;
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h0040, 3, 2, 8'h77);
    @(negedge ref_clk_i);
    wp = 1'b0;
    poll = 1'b1;
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h0100, 1, 2, 8'h33);
    poll = 1'b0;
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h0100, 1, 2, 8'h33);
    for (int t = 0; t < 10; t++) begin
      @(negedge ref_clk_i);
      r = $random(seed);
      pins = r[9:7];
      wp = r[10] & r[11];
      m.slow = int'(r[13:12]);
      wr(r[0] ? EEPW_TYPE_MAIN : EEPW_TYPE_ID, r[1] ? r[9:7] : r[4:2],
         1'b0, r[31:16] & 16'hFBEF, 1 + int'(r[6:5]), 2, r[15:8]);
    end
    @(negedge ref_clk_i);
    pins = 3'h5;
    wp = 1'b0;
    m.slow = 0;
    wr(EEPW_TYPE_ID, 3'h5, 1'b0, 16'h001F, 4, 2, 8'hA0);
    wr(EEPW_TYPE_ID, 3'h5, 1'b0, 16'h0400, 1, 2, 8'hFD);
    wr(EEPW_TYPE_ID, 3'h5, 1'b0, 16'hA7C3, 1, 2, 8'h02);
    wr(EEPW_TYPE_ID, 3'h5, 1'b0, 16'h0005, 2, 2, 8'h44);
    wr(EEPW_TYPE_ID, 3'h5, 1'b0, 16'h0400, 1, 2, 8'h02);
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h1FFF, 1, 2, 8'h99);
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    locked_exp = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check(id_locked_o, 1'b0, "reset lock");
    wr(EEPW_TYPE_MAIN, 3'h5, 1'b0, 16'h0044, 4, 2, 8'hC0);
    print_verdict();
  end
endmodule
